/* File: sps_defines.svh */
// Constants for the SFR page select decoder.
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_PAGE_INDEX_ADDR 8'hac
`define SPS_PAGE_FIELD_MSB 3
`define SPS_PAGE_FIELD_LSB 0
`define SPS_PAGE_RESET 4'h0
`define SPS_PAGE_ZERO 4'h0
`define SPS_PAGE_ONE 4'h1
`define SPS_BANK_COUNT 13
`define SPS_SLOT_NONE 4'hf
`define SPS_ADDR_SERIAL_CTRL 8'h98
`define SPS_ADDR_SERIAL_BUF 8'h99
`define SPS_ADDR_SERIAL_CFG_A 8'h9a
`define SPS_ADDR_SERIAL_CFG_B 8'h9b
`define SPS_ADDR_PULLUP 8'hb4
`define SPS_ADDR_PORT_MODE 8'hb5
`define SPS_ADDR_TIMER_CTRL 8'hc8
`define SPS_ADDR_TIMER_MODE 8'hc9
`define SPS_ADDR_TIMER_RLD_LO 8'hca
`define SPS_ADDR_TIMER_RLD_HI 8'hcb
`define SPS_ADDR_TIMER_CNT_LO 8'hcc
`define SPS_ADDR_TIMER_CNT_HI 8'hcd
`define SPS_ADDR_PORT_LATCH 8'hf8
`endif

/* File: sps_pkg.sv */
// Types for the SFR page select decoder.
package sps_pkg;
  typedef enum logic [2:0] {
    SPS_PEND_NONE,
    SPS_PEND_INDEX,
    SPS_PEND_BANK,
    SPS_PEND_COMMON,
    SPS_PEND_ZERO
  } sps_pend_t;

  typedef struct packed {
    logic [3:0] page;
    logic bank_wr;
    logic bank_rd;
    logic bank_page;
    logic [3:0] bank_slot;
    logic com_wr;
    logic com_rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    sps_pend_t pend;
    logic [7:0] rdata;
    logic rvalid;
  } sps_state_t;
endpackage : sps_pkg

/* File: sps_page_decoder.sv */
// SFR page index register and banked address decoder.
`timescale 1ns/1ns
`include "sps_defines.svh"

// Notes on behaviour
// RULE1: Low four bits of the page index pick the page; 0 and 1 decode.
// RULE2: Only pages 0 and 1 have banked register sets behind them.
// RULE3: Software writes zero into page index bits 7 to 4 every time.
// RULE4: Page index sits at 0xac; low field resets to zero, page 0.
// RULE5: Page 0 maps its 13 registers onto the shared banked addresses.
// RULE6: Page 1 maps 13 other registers onto those same banked addresses.
// RULE7: No hardware save or restore of the page index; only writes change it.
// RULE8: Software loads 0x00 or 0x01 first and preserves it around interrupts.
// RULE9: Non-banked addresses reach the common register whatever the page.
// RULE10: Banked addresses on pages 2 to f: writes dropped, reads zero.
module sps_page_decoder
  import sps_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] bank_rdata_i,
  input wire logic [7:0] common_rdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_rvalid_o,
  output logic [3:0] page_index_o,
  output logic bank_wr_o,
  output logic bank_rd_o,
  output logic bank_page_o,
  output logic [3:0] bank_slot_o,
  output logic common_wr_o,
  output logic common_rd_o,
  output logic [7:0] fwd_addr_o,
  output logic [7:0] fwd_wdata_o
);

  // ==========================================================
  // Address decode
  // Slot numbers 0 to 12 name the banked registers in address order.
  function automatic logic [3:0] bank_slot_of(input logic [7:0] a);
    case (a)
      `SPS_ADDR_SERIAL_CTRL: bank_slot_of = 4'h0;
      `SPS_ADDR_SERIAL_BUF: bank_slot_of = 4'h1;
      `SPS_ADDR_SERIAL_CFG_A: bank_slot_of = 4'h2;
      `SPS_ADDR_SERIAL_CFG_B: bank_slot_of = 4'h3;
      `SPS_ADDR_PULLUP: bank_slot_of = 4'h4;
      `SPS_ADDR_PORT_MODE: bank_slot_of = 4'h5;
      `SPS_ADDR_TIMER_CTRL: bank_slot_of = 4'h6;
      `SPS_ADDR_TIMER_MODE: bank_slot_of = 4'h7;
      `SPS_ADDR_TIMER_RLD_LO: bank_slot_of = 4'h8;
      `SPS_ADDR_TIMER_RLD_HI: bank_slot_of = 4'h9;
      `SPS_ADDR_TIMER_CNT_LO: bank_slot_of = 4'ha;
      `SPS_ADDR_TIMER_CNT_HI: bank_slot_of = 4'hb;
      `SPS_ADDR_PORT_LATCH: bank_slot_of = 4'hc;
      default: bank_slot_of = `SPS_SLOT_NONE;
    endcase
  endfunction : bank_slot_of

  // RULE2: two pages implemented
  function automatic logic page_implemented(input logic [3:0] p);
    page_implemented = (p == `SPS_PAGE_ZERO) || (p == `SPS_PAGE_ONE);
  endfunction : page_implemented

  sps_state_t st;
  sps_state_t next_st;
  logic [3:0] slot;
  logic is_index;
  logic is_bank;
  logic page_ok;

  assign slot = bank_slot_of(sfr_addr_i);
  assign is_index = (sfr_addr_i == `SPS_PAGE_INDEX_ADDR);
  assign is_bank = (slot != `SPS_SLOT_NONE);
  assign page_ok = page_implemented(st.page);

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.bank_wr = 1'b0;
    next_st.bank_rd = 1'b0;
    next_st.com_wr = 1'b0;
    next_st.com_rd = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.pend = SPS_PEND_NONE;
    next_st.addr = sfr_addr_i;
    next_st.wdata = sfr_wdata_i;
    // RULE7: index only on write
    // The page survives interrupts untouched, so handlers must save it.
    if (sfr_wr_i && is_index) begin
      // RULE3: upper bits dropped
      // Reserved upper bits are not stored; software keeps them zero.
      next_st.page = sfr_wdata_i[`SPS_PAGE_FIELD_MSB:`SPS_PAGE_FIELD_LSB];
    end
    // RULE5: page 0 banking
    // RULE6: page 1 banking
    if (is_bank && page_ok) begin
      next_st.bank_wr = sfr_wr_i;
      next_st.bank_rd = sfr_rd_i;
      // RULE1: page field decode
      next_st.bank_page = (st.page == `SPS_PAGE_ONE);
      next_st.bank_slot = slot;
    end
    // RULE9: common path unpaged
    if (!is_bank && !is_index) begin
      next_st.com_wr = sfr_wr_i;
      next_st.com_rd = sfr_rd_i;
    end
    if (sfr_rd_i) begin
      if (is_index) begin
        next_st.pend = SPS_PEND_INDEX;
      end else if (!is_bank) begin
        next_st.pend = SPS_PEND_COMMON;
      end else if (page_ok) begin
        next_st.pend = SPS_PEND_BANK;
      end else begin
        // RULE10: unmapped page reads
        next_st.pend = SPS_PEND_ZERO;
      end
    end
    // Read data is captured one cycle after the strobe so that the
    // peripheral answers combinationally from its registered strobe.
    case (st.pend)
      SPS_PEND_NONE: next_st.rdata = st.rdata;
      SPS_PEND_INDEX: next_st.rdata = {4'h0, st.page};
      SPS_PEND_BANK: next_st.rdata = bank_rdata_i;
      SPS_PEND_COMMON: next_st.rdata = common_rdata_i;
      SPS_PEND_ZERO: next_st.rdata = 8'h00;
      default: next_st.rdata = 8'h00;
    endcase
    next_st.rvalid = (st.pend != SPS_PEND_NONE);
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      // RULE4: page zero at reset
      st <= '0;
      st.page <= `SPS_PAGE_RESET;
      st.pend <= SPS_PEND_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata_o = st.rdata;
  assign sfr_rvalid_o = st.rvalid;
  assign page_index_o = st.page;
  assign bank_wr_o = st.bank_wr;
  assign bank_rd_o = st.bank_rd;
  assign bank_page_o = st.bank_page;
  assign bank_slot_o = st.bank_slot;
  assign common_wr_o = st.com_wr;
  assign common_rd_o = st.com_rd;
  assign fwd_addr_o = st.addr;
  assign fwd_wdata_o = st.wdata;

  // ==========================================================
  // Assertions
  // RULE1: page select decode
  page_decode_a: assert property ( // RULE1
    @(posedge ref_clk_i) disable iff (rst_i)
    (sfr_wr_i || sfr_rd_i) && is_bank && page_ok |=>
    (bank_wr_o || bank_rd_o) && bank_page_o == $past(st.page[0]))
    else $error("Banked strobe shows the wrong page.");

  // RULE2: two pages only
  two_pages_a: assert property ( // RULE2
    @(posedge ref_clk_i) disable iff (rst_i)
    (bank_wr_o || bank_rd_o) |-> $past(st.page) <= `SPS_PAGE_ONE)
    else $error("Bank strobe issued for an unimplemented page.");

  // RULE4: index reset value
  // Written as an implication on the reset level so that the very first
  // clock edge, before any reset has been seen, is not checked.
  index_reset_a: assert property ( // RULE4
    @(posedge ref_clk_i)
    rst_i |=> page_index_o == `SPS_PAGE_RESET)
    else $error("Page index not zero after reset.");

  // RULE4: index readback
  index_read_a: assert property ( // RULE4
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_rd_i && is_index && !sfr_wr_i |-> ##2
    sfr_rvalid_o && sfr_rdata_o == {4'h0, $past(page_index_o, 1)})
    else $error("Page index read returned the wrong value.");

  // RULE5: page 0 slots
  page0_map_a: assert property ( // RULE5
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_wr_i && is_bank && st.page == `SPS_PAGE_ZERO |=>
    bank_wr_o && !bank_page_o && bank_slot_o == $past(slot) &&
    bank_slot_o < `SPS_BANK_COUNT && fwd_wdata_o == $past(sfr_wdata_i))
    else $error("Page 0 write not routed to a page 0 slot.");

  // RULE6: page 1 slots
  page1_map_a: assert property ( // RULE6
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_wr_i && is_bank && st.page == `SPS_PAGE_ONE |=>
    bank_wr_o && bank_page_o && bank_slot_o == $past(slot))
    else $error("Page 1 write not routed to the page 1 slot.");

  // RULE7: index holds steady
  index_hold_a: assert property ( // RULE7
    @(posedge ref_clk_i) disable iff (rst_i)
    !(sfr_wr_i && is_index) |=> $stable(page_index_o))
    else $error("Page index changed without a write.");

  // RULE9: common ignores page
  common_path_a: assert property ( // RULE9
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_wr_i && !is_bank && !is_index |=>
    common_wr_o && !bank_wr_o && fwd_addr_o == $past(sfr_addr_i))
    else $error("Common write lost or sent to a bank.");

  // RULE9: common read timing
  common_read_a: assert property ( // RULE9
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_rd_i && !is_bank && !is_index |=>
    common_rd_o && !bank_rd_o ##1 sfr_rvalid_o)
    else $error("Common read strobe or reply missing.");

  // RULE10: unmapped page zero
  unmapped_a: assert property ( // RULE10
    @(posedge ref_clk_i) disable iff (rst_i)
    (sfr_wr_i || sfr_rd_i) && is_bank && !page_ok |=>
    !bank_wr_o && !bank_rd_o ##1 (sfr_rdata_o == 8'h00 || !sfr_rvalid_o))
    else $error("Unmapped page access reached a bank.");

  // RULE10: unmapped read zero
  unmapped_read_a: assert property ( // RULE10
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_rd_i && is_bank && !page_ok |-> ##2
    sfr_rvalid_o && sfr_rdata_o == 8'h00)
    else $error("Unmapped page read did not return zero.");

  page1_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    sfr_wr_i && is_index && sfr_wdata_i == 8'h01 ##[1:2]
    sfr_rd_i && is_bank);
  page0_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    bank_wr_o && !bank_page_o);
  unmapped_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    sfr_rd_i && is_bank && !page_ok);
  common_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    common_rd_o ##1 sfr_rvalid_o);

endmodule : sps_page_decoder

/* File: sps_periph_model.sv */
// Behavioural model of the banked and common registers behind the decoder.
`timescale 1ns/1ns
module sps_periph_model (
  input wire logic ref_clk_i,
  input wire logic bank_wr_i,
  input wire logic bank_rd_i,
  input wire logic bank_page_i,
  input wire logic [3:0] bank_slot_i,
  input wire logic common_wr_i,
  input wire logic common_rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] bank_rdata_o,
  output logic [7:0] common_rdata_o
);
  // ==========================================================
  // Storage
  // two separate sets of 13.
  logic [7:0] bank [0:1][0:12];
  logic [7:0] common [0:255];
  logic [7:0] bval;
  initial begin
    foreach (bank[p, s]) bank[p][s] = 8'h00;
    foreach (common[i]) common[i] = 8'h00;
  end
  assign bval = (bank_slot_i < 4'hd) ? bank[bank_page_i][bank_slot_i] : 8'hee;
  // An unread line shows the inverse, so stale data never passes for a reply.
  assign bank_rdata_o = bank_rd_i ? bval : ~bval;
  assign common_rdata_o = common_rd_i ? common[addr_i] : ~common[addr_i];
  always @(posedge ref_clk_i) begin
    if (bank_wr_i && bank_slot_i < 4'hd) begin
      bank[bank_page_i][bank_slot_i] <= wdata_i;
    end
    if (common_wr_i) begin
      common[addr_i] <= wdata_i;
    end
  end
endmodule : sps_periph_model

/* File: test_sps_page_decoder.sv */
// Self-checking bench for the SFR page select decoder.
`timescale 1ns/1ns
`include "sps_defines.svh"
module test_sps_page_decoder;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] bank_rdata_i, common_rdata_i, sfr_rdata_o;
  logic [7:0] fwd_addr_o, fwd_wdata_o, rdv;
  logic sfr_rvalid_o, bank_wr_o, bank_rd_o, bank_page_o;
  logic common_wr_o, common_rd_o;
  logic [3:0] page_index_o, bank_slot_o;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] banked [0:12] = '{8'h98, 8'h99, 8'h9a, 8'h9b, 8'hb4,
    8'hb5, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hf8};
  sps_page_decoder i_sps_page_decoder (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .bank_rdata_i(bank_rdata_i), .common_rdata_i(common_rdata_i),
    .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o),
    .page_index_o(page_index_o), .bank_wr_o(bank_wr_o),
    .bank_rd_o(bank_rd_o), .bank_page_o(bank_page_o),
    .bank_slot_o(bank_slot_o), .common_wr_o(common_wr_o),
    .common_rd_o(common_rd_o), .fwd_addr_o(fwd_addr_o),
    .fwd_wdata_o(fwd_wdata_o));
  sps_periph_model i_sps_periph_model (.ref_clk_i(ref_clk_i),
    .bank_wr_i(bank_wr_o), .bank_rd_i(bank_rd_o),
    .bank_page_i(bank_page_o), .bank_slot_i(bank_slot_o),
    .common_wr_i(common_wr_o), .common_rd_i(common_rd_o),
    .addr_i(fwd_addr_o), .wdata_i(fwd_wdata_o),
    .bank_rdata_o(bank_rdata_i), .common_rdata_o(common_rdata_i));
  // ==========================================================
  // Tasks
  task automatic finish_test();
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd_i <= 1'b0;
    for (int n = 0; n < 6 && sfr_rvalid_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (sfr_rvalid_o !== 1'b1) begin
      errors++;
      finish_test();
    end else begin
      d = sfr_rdata_o;
    end
  endtask : rd
  // ==========================================================
  // Sequence
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(`SPS_PAGE_INDEX_ADDR, rdv);
    chk("index after reset", 8'h00, rdv);
    for (int p = 0; p < 2; p++) begin
      wr(`SPS_PAGE_INDEX_ADDR, p[7:0]);
      foreach (banked[i]) wr(banked[i], {p[3:0], i[3:0]} ^ 8'ha5);
    end
    for (int p = 1; p >= 0; p--) begin
      wr(`SPS_PAGE_INDEX_ADDR, p[7:0]);
      #1;
      chk("page field", {4'h0, p[3:0]}, {4'h0, page_index_o});
      foreach (banked[i]) begin
        rd(banked[i], rdv);
        chk("banked read", {p[3:0], i[3:0]} ^ 8'ha5, rdv);
      end
    end
    // Software keeps the reserved upper bits zero on every index write.
    wr(`SPS_PAGE_INDEX_ADDR, 8'h03);
    rd(`SPS_PAGE_INDEX_ADDR, rdv);
    chk("index reserved bits", 8'h03, rdv);
    wr(banked[0], 8'h77);
    rd(banked[0], rdv);
    chk("unmapped page read", 8'h00, rdv);
    wr(8'h80, 8'h3c);
    wr(`SPS_PAGE_INDEX_ADDR, 8'h00);
    rd(banked[0], rdv);
    chk("page 0 unchanged", 8'ha5, rdv);
    rd(8'h80, rdv);
    chk("common read", 8'h3c, rdv);
    chk("page persists", 8'h00, {4'h0, page_index_o});
    // A reset in mid-run must bring a selected page 1 back to page 0.
    wr(`SPS_PAGE_INDEX_ADDR, 8'h01);
    #1;
    chk("page before reset", 8'h01, {4'h0, page_index_o});
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("page after reset", 8'h00, {4'h0, page_index_o});
    rd(`SPS_PAGE_INDEX_ADDR, rdv);
    chk("index read after reset", 8'h00, rdv);
    finish_test();
  end
endmodule : test_sps_page_decoder
